//--- logic/om_control_status.sv
// Control and status logic of a pluggable optical module
// Notes on behaviour
// [R1] Rising transmit-off pin turns the laser off within 10 us.
// [R2] Falling transmit-off pin restores the laser within 1 ms.
// [R3] Power-on or transmit-off release: init, fault cleared, laser on within 300 ms.
// [R4] A laser fault drives the fault pin within 100 us.
// [R5] Transmit-off held 10 us clears a latched fault shutdown.
// [R6] Loss of light drives the signal-lost pin within 100 us.
// [R7] Return of light releases the signal-lost pin within 100 us.
// [R8] Soft transmit-off bit 6 of byte 0x6E turns laser off after stop.
// [R9] Clearing the soft transmit-off bit restores the laser within 100 ms.
// [R10] Fault mirror bit 2 of byte 0x6E sets within 100 ms.
// [R11] Signal-lost mirror bit 1 of byte 0x6E sets within 100 ms.
// [R12] Signal-lost mirror bit 1 clears within 100 ms of light returning.
// [R13] Data-ready bit 0 of byte 0x6E sets within 1000 ms of power-on.
// [R14] Serial bus serves both spaces no later than 300 ms after power-on.
// [R15] A 1 to 8 byte write completes within 10 ms of stop.
// [R16] Host clocks the serial bus at 100 kHz at most.
// [R17] Supply readback comes from the transmit supply rail only.
// [R18] Host waits out the write cycle or polls for acknowledge.
// [R19] Hardware and software transmit-off requests are ORed.
module om_control_status
    import om_pkg::*;
#(
    parameter int SERIAL_CYCLES = SERIAL_READY_CYCLES,
    parameter int WRITE_CYCLES = WRITE_CYCLE_CYCLES
) (
    // Clock and reset
    input wire logic clock,
    input wire logic rst,
    // Host control pins
    input wire logic tx_off_pin,
    output logic laser_fault_pin,
    output logic signal_lost_flag,
    // Two-wire serial bus, open drain
    input wire logic scl,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe_n,
    // Optics side
    input wire logic laser_fault_raw,
    input wire logic light_present,
    input wire logic [7:0] transmit_supply_rail,
    output logic laser_enable
);

    logic tx_off_s;
    logic fault_s;
    logic light_s;
    logic scl_s;
    logic sda_s;
    logic scl_q;
    logic sda_q;
    logic scl_rise;
    logic scl_fall;
    logic bus_start;
    logic bus_stop;
    logic serial_ready;
    logic hold_done;
    logic wr_done;
    logic wr_busy;
    logic wr_start;
    logic soft_off;
    logic pend_valid;
    logic pend_soft;
    logic dev_match;
    logic dev_diag;
    logic mack_ok;
    logic [7:0] supply_q;
    logic [7:0] csb;
    logic [7:0] rd_val;
    logic [7:0] shreg;
    logic [7:0] out_byte;
    logic [7:0] mem_ptr;
    logic [3:0] bit_cnt;
    logic [3:0] wr_count;
    om_bus_state_e state;
    om_bus_state_e ack_next;

    // Every pin and optics input but the supply rail is asynchronous to the core clock
    // Reset to idle levels (bus lines high) so the edge detectors see no false edge
    om_sync2 #(
        .W(5),
        .RST_VAL(5'h03)
    ) u_sync (
        .clock(clock),
        .rst(rst),
        .async_in({tx_off_pin, laser_fault_raw, light_present, scl, sda_in}),
        .sync_out({tx_off_s, fault_s, light_s, scl_s, sda_s})
    );

    // Power-on timer gates the serial slave and the data-ready bit
    om_timer #(
        .CYCLES(SERIAL_CYCLES)
    ) u_powerup (
        .clock(clock),
        .rst(rst),
        .run(1'b1),
        .done(serial_ready)
    );

    // Transmit-off must stand unbroken for the hold time to clear a fault
    om_timer #(
        .CYCLES(HOLD_CYCLES)
    ) u_hold (
        .clock(clock),
        .rst(rst),
        .run(tx_off_s),
        .done(hold_done)
    );

    // Internal write cycle after a write burst
    om_timer #(
        .CYCLES(WRITE_CYCLES)
    ) u_write (
        .clock(clock),
        .rst(rst),
        .run(wr_busy),
        .done(wr_done)
    );

    // Only the pull-down is ever driven on the open-drain line
    assign sda_out = 1'b0;

    // Bus edges from the synchronised copies and their previous values
    assign scl_rise = scl_s && !scl_q;
    assign scl_fall = !scl_s && scl_q;
    assign bus_start = scl_s && scl_q && sda_q && !sda_s;
    assign bus_stop = scl_s && scl_q && !sda_q && sda_s;
    assign dev_match = (shreg[7:1] == DEV_ID_SPACE[7:1]) || (shreg[7:1] == DEV_DIAG_SPACE[7:1]);

    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            scl_q <= 1'b1;
            sda_q <= 1'b1;
        end
        else
        begin
            scl_q <= scl_s;
            sda_q <= sda_s;
        end
    end

    // Control/status byte assembled from live state
    always_comb
    begin
        csb = 8'h00;
        csb[CSB_TXOFF_STATE_BIT] = tx_off_s;
        csb[CSB_SOFT_OFF_BIT] = soft_off;
        // [R10] fault mirror bit
        csb[CSB_FAULT_BIT] = laser_fault_pin;
        // [R11] [R12] signal-lost mirror
        csb[CSB_LOST_BIT] = signal_lost_flag;
        // [R13] data ready after power-on
        csb[CSB_READY_BIT] = serial_ready;
    end

    // Read mux; unmapped bytes read as zero
    always_comb
    begin
        rd_val = 8'h00;
        if (dev_diag && mem_ptr == CSB_OFFSET)
            rd_val = csb;
        else if (dev_diag && mem_ptr == SUPPLY_OFFSET)
            rd_val = supply_q;
    end

    // [R17] transmit rail only
    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
            supply_q <= 8'h00;
        else
            supply_q <= transmit_supply_rail;
    end

    // [R19] ORed transmit-off requests, plus fault shutdown
    // [R1] [R2] [R3] [R9] laser follows requests directly
    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
            laser_enable <= 1'b0;
        else
            laser_enable <= !(tx_off_s || soft_off || laser_fault_pin || fault_s);
    end

    // [R4] [R5] fault latch, a new fault wins over the clear
    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
            laser_fault_pin <= 1'b0;
        else if (fault_s)
            laser_fault_pin <= 1'b1;
        else if (hold_done)
            laser_fault_pin <= 1'b0;
    end

    // [R6] [R7] signal-lost pin tracks light
    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
            signal_lost_flag <= 1'b1;
        else
            signal_lost_flag <= !light_s;
    end

    // [R15] write cycle busy, a new start wins over completion
    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
            wr_busy <= 1'b0;
        else if (wr_start)
            wr_busy <= 1'b1;
        else if (wr_done)
            wr_busy <= 1'b0;
    end

    // Serial slave: shifts on SCL rise, drives SDA after SCL fall
    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            state <= ST_IDLE;
            ack_next <= ST_IDLE;
            bit_cnt <= 4'h0;
            shreg <= 8'h00;
            out_byte <= 8'h00;
            mem_ptr <= 8'h00;
            dev_diag <= 1'b0;
            mack_ok <= 1'b0;
            sda_oe_n <= 1'b1;
            wr_count <= 4'h0;
            wr_start <= 1'b0;
            pend_valid <= 1'b0;
            pend_soft <= 1'b0;
            soft_off <= SOFT_OFF_RESET;
        end
        else
        begin
            wr_start <= 1'b0;
            if (bus_stop)
            begin
                state <= ST_IDLE;
                sda_oe_n <= 1'b1;
                wr_count <= 4'h0;
                // [R8] soft transmit-off takes effect at stop
                if (pend_valid)
                    soft_off <= pend_soft;
                pend_valid <= 1'b0;
                if (wr_count != 4'h0)
                    wr_start <= 1'b1;
            end
            else if (bus_start)
            begin
                state <= ST_DEV;
                bit_cnt <= 4'h0;
                sda_oe_n <= 1'b1;
            end
            else if (scl_rise)
            begin
                if (state == ST_DEV || state == ST_ADDR || state == ST_WDATA)
                begin
                    shreg <= {shreg[6:0], sda_s};
                    bit_cnt <= bit_cnt + 1'b1;
                end
                else if (state == ST_MACK)
                    mack_ok <= !sda_s;
            end
            else if (scl_fall)
            begin
                unique case (state)
                    ST_IDLE:
                        sda_oe_n <= 1'b1;
                    ST_DEV:
                        if (bit_cnt == BYTE_BITS)
                        begin
                            bit_cnt <= 4'h0;
                            // [R14] [R18] no acknowledge before ready or while writing
                            if (dev_match && serial_ready && !wr_busy)
                            begin
                                dev_diag <= shreg[1];
                                sda_oe_n <= 1'b0;
                                state <= ST_ACK;
                                ack_next <= shreg[0] ? ST_RDATA : ST_ADDR;
                            end
                            else
                                state <= ST_IDLE;
                        end
                    ST_ADDR:
                        if (bit_cnt == BYTE_BITS)
                        begin
                            bit_cnt <= 4'h0;
                            mem_ptr <= shreg;
                            sda_oe_n <= 1'b0;
                            state <= ST_ACK;
                            ack_next <= ST_WDATA;
                        end
                    ST_WDATA:
                        if (bit_cnt == BYTE_BITS)
                        begin
                            bit_cnt <= 4'h0;
                            // [R15] bytes beyond the eighth of a burst are refused
                            if (wr_count < MAX_WRITE_BYTES)
                            begin
                                if (dev_diag && mem_ptr == CSB_OFFSET)
                                begin
                                    pend_valid <= 1'b1;
                                    pend_soft <= shreg[CSB_SOFT_OFF_BIT];
                                end
                                mem_ptr <= mem_ptr + 1'b1;
                                wr_count <= wr_count + 1'b1;
                                sda_oe_n <= 1'b0;
                                state <= ST_ACK;
                                ack_next <= ST_WDATA;
                            end
                            else
                                state <= ST_IDLE;
                        end
                    ST_ACK:
                    begin
                        state <= ack_next;
                        sda_oe_n <= 1'b1;
                        if (ack_next == ST_RDATA)
                        begin
                            out_byte <= rd_val;
                            sda_oe_n <= rd_val[7];
                            bit_cnt <= 4'h1;
                        end
                    end
                    ST_RDATA:
                        if (bit_cnt == BYTE_BITS)
                        begin
                            sda_oe_n <= 1'b1;
                            mem_ptr <= mem_ptr + 1'b1;
                            state <= ST_MACK;
                        end
                        else
                        begin
                            sda_oe_n <= out_byte[~bit_cnt[2:0]];
                            bit_cnt <= bit_cnt + 1'b1;
                        end
                    ST_MACK:
                        if (mack_ok)
                        begin
                            out_byte <= rd_val;
                            sda_oe_n <= rd_val[7];
                            bit_cnt <= 4'h1;
                            state <= ST_RDATA;
                        end
                        else
                            state <= ST_IDLE;
                endcase
            end
        end
    end

    a_hw_off_fast: assert property (@(posedge clock) disable iff (rst) // [R1]
        tx_off_s |=> !laser_enable)
        else $error("laser still on after transmit-off");

    a_hw_on_restore: assert property (@(posedge clock) disable iff (rst) // [R2]
        $fell(tx_off_s) && !soft_off && !laser_fault_pin && !fault_s |=> laser_enable)
        else $error("laser not restored after transmit-off release");

    a_fault_pin_set: assert property (@(posedge clock) disable iff (rst) // [R4]
        fault_s |=> laser_fault_pin && !laser_enable)
        else $error("fault pin not set by fault");

    a_fault_clear_hold: assert property (@(posedge clock) disable iff (rst) // [R5]
        $fell(laser_fault_pin) |-> $past(hold_done) && $past(tx_off_s, 2))
        else $error("fault cleared without hold time");

    a_lost_follow: assert property (@(posedge clock) disable iff (rst) // [R6]
        !light_s |=> signal_lost_flag ##0 csb[CSB_LOST_BIT])
        else $error("signal-lost not raised");

    a_lost_release: assert property (@(posedge clock) disable iff (rst) // [R7]
        light_s ##1 light_s |-> !signal_lost_flag)
        else $error("signal-lost not released");

    a_soft_off_stop: assert property (@(posedge clock) disable iff (rst) // [R8]
        bus_stop && pend_valid && pend_soft |=> soft_off ##1 !laser_enable)
        else $error("soft transmit-off not applied after stop");

    a_fault_mirror: assert property (@(posedge clock) disable iff (rst) // [R10]
        csb[CSB_FAULT_BIT] == laser_fault_pin)
        else $error("fault mirror differs from fault pin");

    a_ready_bit: assert property (@(posedge clock) disable iff (rst) // [R13]
        $rose(serial_ready) |-> csb[CSB_READY_BIT] && !$past(csb[CSB_READY_BIT]))
        else $error("data-ready bit wrong at power-on");

    a_no_early_ack: assert property (@(posedge clock) disable iff (rst) // [R14]
        !serial_ready |-> sda_oe_n)
        else $error("bus driven before ready");

    a_write_end: assert property (@(posedge clock) disable iff (rst) // [R15]
        wr_busy && wr_done && !wr_start |=> !wr_busy)
        else $error("write cycle did not end");

endmodule

//--- logic/om_pkg.sv
// Shared constants and types for the optical module control and status logic
package om_pkg;

    // Core clock period in nanoseconds
    localparam int CLK_PERIOD_NS = 100;

    // Fault shutdown reset hold: least time, rounded up to whole cycles
    localparam int T_HOLD_US = 10;
    localparam int HOLD_CYCLES = (T_HOLD_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // Serial bus ready after power-on: longest time, rounded down
    localparam int T_SERIAL_MS = 300;
    localparam int SERIAL_READY_CYCLES = (T_SERIAL_MS * 1000000) / CLK_PERIOD_NS;

    // Internal write cycle: longest time, rounded down
    localparam int T_WRITE_MS = 10;
    localparam int WRITE_CYCLE_CYCLES = (T_WRITE_MS * 1000000) / CLK_PERIOD_NS;

    // Two-wire device addresses of the two memory spaces
    localparam logic [7:0] DEV_ID_SPACE = 8'hA0;
    localparam logic [7:0] DEV_DIAG_SPACE = 8'hA2;

    // Byte offsets in the diagnostic space
    localparam logic [7:0] SUPPLY_OFFSET = 8'h62;
    localparam logic [7:0] CSB_OFFSET = 8'h6E;

    // Field positions in the control/status byte
    localparam int CSB_TXOFF_STATE_BIT = 7;
    localparam int CSB_SOFT_OFF_BIT = 6;
    localparam int CSB_FAULT_BIT = 2;
    localparam int CSB_LOST_BIT = 1;
    localparam int CSB_READY_BIT = 0;

    // Reset value of the software transmit-off bit
    localparam logic SOFT_OFF_RESET = 1'b0;

    // Bits per byte and largest write burst
    localparam logic [3:0] BYTE_BITS = 4'h8;
    localparam logic [3:0] MAX_WRITE_BYTES = 4'h8;

    // Serial slave states
    typedef enum logic [2:0] {ST_IDLE, ST_DEV, ST_ADDR, ST_WDATA, ST_ACK, ST_RDATA, ST_MACK}
        om_bus_state_e;

endpackage

//--- logic/om_sync2.sv
// Two flip-flop synchroniser for a group of asynchronous inputs
module om_sync2 #(
    parameter int W = 1,
    parameter logic [W-1:0] RST_VAL = '0
) (
    // Clock and reset
    input wire logic clock,
    input wire logic rst,
    // Asynchronous in, synchronous out
    input wire logic [W-1:0] async_in,
    output logic [W-1:0] sync_out
);

    logic [W-1:0] meta;

    // First stage is read only by the second stage
    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            meta <= RST_VAL;
            sync_out <= RST_VAL;
        end
        else
        begin
            meta <= async_in;
            sync_out <= meta;
        end
    end

endmodule

//--- logic/om_timer.sv
// Saturating cycle timer: done rises once run has stood for CYCLES + 1 cycles
module om_timer #(
    parameter int CYCLES = 100
) (
    // Clock and reset
    input wire logic clock,
    input wire logic rst,
    // Run level and completion level
    input wire logic run,
    output logic done
);

    localparam int W = $clog2(CYCLES + 1);
    localparam logic [W-1:0] TOP = W'(CYCLES);

    logic [W-1:0] count;

    // Dropping run restarts the count, so only an unbroken run completes
    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            count <= '0;
            done <= 1'b0;
        end
        else if (!run)
        begin
            count <= '0;
            done <= 1'b0;
        end
        else
        begin
            if (count != TOP)
                count <= count + 1'b1;
            done <= (count == TOP);
        end
    end

endmodule

//--- tb/om_host_model.sv
// Host board model: two-wire bus master toward the module
module om_host_model
    import om_pkg::*;
(
    // Clock
    input wire logic clock,
    // Two-wire bus: wire level in, clock and pull-down out
    input wire logic sda,
    output logic scl,
    output logic host_low
);
    timeunit 1ns;
    timeprecision 1ns;

    // Half bit period in core cycles
    localparam int H = 50;

    // Bus idles released, clock high
    initial
    begin
        scl = 1'b1;
        host_low = 1'b0;
    end

    task automatic tick(input int n);
        repeat (n) @(posedge clock);
    endtask

    // bit period 10 us
    // Data moves well after the clock fall so the device never sees a false start or stop
    task automatic bit_cycle(input logic drive_low, output logic seen);
        tick(10);
        host_low <= drive_low;
        tick(H - 10);
        scl <= 1'b1;
        tick(H / 2);
        seen = sda;
        tick(H / 2);
        scl <= 1'b0;
    endtask

    // Start, also usable as a repeated start
    task automatic bus_start();
        tick(10);
        host_low <= 1'b0;
        tick(H - 10);
        scl <= 1'b1;
        tick(H);
        host_low <= 1'b1;
        tick(H);
        scl <= 1'b0;
    endtask

    task automatic bus_stop();
        tick(10);
        host_low <= 1'b1;
        tick(H - 10);
        scl <= 1'b1;
        tick(H);
        host_low <= 1'b0;
        tick(H);
    endtask

    // Byte out MSB first; ack true when the ninth bit was pulled low
    task automatic put_byte(input logic [7:0] b, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--)
            bit_cycle(~b[i], s);
        bit_cycle(1'b0, s);
        ack = ~s;
    endtask

    task automatic get_byte(input logic last, output logic [7:0] d);
        logic s;
        for (int i = 7; i >= 0; i--)
        begin
            bit_cycle(1'b0, s);
            d[i] = s;
        end
        bit_cycle(~last, s);
    endtask

    task automatic probe(input logic [7:0] dev, output logic ack);
        bus_start();
        put_byte(dev, ack);
        bus_stop();
    endtask

    task automatic write_reg(input logic [7:0] a, input logic [7:0] d, output logic ok);
        logic k1, k2, k3;
        bus_start();
        put_byte(DEV_DIAG_SPACE, k1);
        put_byte(a, k2);
        put_byte(d, k3);
        bus_stop();
        ok = k1 & k2 & k3;
    endtask

    // Random read: set pointer, repeated start, one byte closed by NACK
    task automatic read_reg(input logic [7:0] a, output logic [7:0] d, output logic ok);
        logic k1, k2, k3;
        bus_start();
        put_byte(DEV_DIAG_SPACE, k1);
        put_byte(a, k2);
        bus_start();
        put_byte(DEV_DIAG_SPACE | 8'h01, k3);
        get_byte(1'b1, d);
        bus_stop();
        ok = k1 & k2 & k3;
    endtask

    // Sequential read: first byte closed by ACK, second by NACK
    task automatic read_pair(input logic [7:0] a, output logic [15:0] d, output logic ok);
        logic k1, k2, k3;
        bus_start();
        put_byte(DEV_DIAG_SPACE, k1);
        put_byte(a, k2);
        bus_start();
        put_byte(DEV_DIAG_SPACE | 8'h01, k3);
        get_byte(1'b0, d[15:8]);
        get_byte(1'b1, d[7:0]);
        bus_stop();
        ok = k1 & k2 & k3;
    endtask

    // Burst of n copies of d from address a; bit i of acks tells if data byte i was taken
    task automatic write_burst(input logic [7:0] a, input logic [7:0] d, input int n,
        output logic [15:0] acks);
        logic k;
        acks = 16'h0000;
        bus_start();
        put_byte(DEV_DIAG_SPACE, k);
        put_byte(a, k);
        for (int i = 0; i < n; i++)
        begin
            put_byte(d, k);
            acks[i] = k;
        end
        bus_stop();
    endtask
endmodule

//--- tb/tb_top.sv
// Self-checking bench for the optical module control and status block
module tb_top
    import om_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;

    // Shortened power-up and write-cycle counts
    localparam int SER_CYC = 1500;
    localparam int WR_CYC = 2000;
    // Response limits in core cycles
    localparam int LIM_OFF = 10000 / CLK_PERIOD_NS;
    localparam int LIM_ON = 1000000 / CLK_PERIOD_NS;
    localparam int LIM_FLT = 100000 / CLK_PERIOD_NS;
    localparam int LIM_SOFT = 100000000 / CLK_PERIOD_NS;
    localparam int CEILING = 90000;

    logic clock, rst, tx_off_pin, laser_fault_raw, light_present;
    logic [7:0] transmit_supply_rail;
    wire scl, host_low, sda, sda_out, sda_oe_n;
    wire laser_fault_pin, signal_lost_flag, laser_enable;
    int bad_count, num_checks;
    int cycles = 0;

    // Open-drain wire with pull-up: either party may pull it low
    assign sda = host_low ? 1'b0 : (sda_oe_n ? 1'b1 : sda_out);

    om_control_status #(
        .SERIAL_CYCLES(SER_CYC),
        .WRITE_CYCLES(WR_CYC)
    ) i_om_control_status (
        .clock(clock), .rst(rst), .tx_off_pin(tx_off_pin),
        .laser_fault_pin(laser_fault_pin), .signal_lost_flag(signal_lost_flag),
        .scl(scl), .sda_in(sda), .sda_out(sda_out), .sda_oe_n(sda_oe_n),
        .laser_fault_raw(laser_fault_raw), .light_present(light_present),
        .transmit_supply_rail(transmit_supply_rail), .laser_enable(laser_enable)
    );

    om_host_model i_om_host_model (.clock(clock), .sda(sda), .scl(scl), .host_low(host_low));

    initial
    begin
        clock = 1'b0;
        forever #50 clock = ~clock;
    end

    task automatic give_verdict();
        $display("Checks %0d, mismatches %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    // Hang guard
    always @(posedge clock)
    begin
        cycles <= cycles + 1;
        if (cycles == CEILING)
        begin
            bad_count++;
            give_verdict();
        end
    end

    task automatic tick(input int n);
        repeat (n) @(posedge clock);
    endtask

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        num_checks++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("Error at %0t: saw %h, expected %h", $time, seen, exp);
        end
    endtask

    // Bounded wait for one output to reach a level; late or never is a mismatch
    task automatic wait_out(input int sel, input logic val, input int lim);
        logic cur;
        for (int n = 0; n <= lim; n++)
        begin
            @(posedge clock);
            cur = sel == 0 ? laser_enable : (sel == 1 ? laser_fault_pin : signal_lost_flag);
            if (cur === val)
                break;
        end
        check({7'h00, cur}, {7'h00, val});
    endtask

    task automatic expect_reg(input logic [7:0] a, input logic [7:0] exp);
        logic [7:0] d;
        logic ok;
        i_om_host_model.read_reg(a, d, ok);
        check({7'h00, ok}, 8'h01);
        check(d, exp);
    endtask

    task automatic put_reg(input logic [7:0] a, input logic [7:0] d);
        logic ok;
        i_om_host_model.write_reg(a, d, ok);
        check({7'h00, ok}, 8'h01);
    endtask

    // Power-up: laser on, bus refused early, then status and supply readback
    task automatic t_boot();
        logic ack;
        logic ok;
        logic [15:0] pair;
        wait_out(0, 1'b1, LIM_ON);
        i_om_host_model.probe(DEV_DIAG_SPACE, ack);
        check({7'h00, ack}, 8'h00);
        expect_reg(CSB_OFFSET, 8'h03);
        expect_reg(SUPPLY_OFFSET, 8'hA5);
        i_om_host_model.probe(DEV_ID_SPACE, ack);
        check({7'h00, ack}, 8'h01);
        i_om_host_model.probe(8'hA4, ack);
        check({7'h00, ack}, 8'h00);
        i_om_host_model.read_pair(SUPPLY_OFFSET - 8'h01, pair, ok);
        check({7'h00, ok}, 8'h01);
        check(pair[15:8], 8'h00);
        check(pair[7:0], 8'hA5);
    endtask

    task automatic t_hw();
        tx_off_pin <= 1'b1;
        wait_out(0, 1'b0, LIM_OFF);
        tx_off_pin <= 1'b0;
        wait_out(0, 1'b1, LIM_ON);
    endtask

    task automatic t_light(input logic lit, input logic [7:0] exp);
        light_present <= lit;
        wait_out(2, ~lit, LIM_FLT);
        expect_reg(CSB_OFFSET, exp);
    endtask

    // Fault latch: a short hold is refused, a full hold clears it
    task automatic t_fault();
        laser_fault_raw <= 1'b1;
        wait_out(1, 1'b1, LIM_FLT);
        expect_reg(CSB_OFFSET, 8'h05);
        laser_fault_raw <= 1'b0;
        tx_off_pin <= 1'b1;
        tick(HOLD_CYCLES / 2);
        tx_off_pin <= 1'b0;
        tick(20);
        check({7'h00, laser_fault_pin}, 8'h01);
        tx_off_pin <= 1'b1;
        tick(HOLD_CYCLES + 20);
        check({7'h00, laser_fault_pin}, 8'h00);
        expect_reg(CSB_OFFSET, 8'h81);
        tx_off_pin <= 1'b0;
        wait_out(0, 1'b1, LIM_ON);
    endtask

    // Software off, busy write cycle, OR with the pin, unmapped byte
    task automatic t_soft();
        logic ack;
        logic [15:0] acks;
        put_reg(CSB_OFFSET, 8'h40);
        wait_out(0, 1'b0, LIM_SOFT);
        i_om_host_model.probe(DEV_DIAG_SPACE, ack);
        check({7'h00, ack}, 8'h00);
        tick(WR_CYC);
        expect_reg(CSB_OFFSET, 8'h41);
        tx_off_pin <= 1'b1;
        put_reg(CSB_OFFSET, 8'h00);
        tick(100);
        check({7'h00, laser_enable}, 8'h00);
        tx_off_pin <= 1'b0;
        wait_out(0, 1'b1, LIM_SOFT);
        tick(WR_CYC);
        put_reg(8'h10, 8'h5A);
        tick(WR_CYC);
        expect_reg(8'h10, 8'h00);
        i_om_host_model.write_burst(8'h10, 8'h5A, 9, acks);
        check(acks[7:0], 8'hFF);
        check(acks[15:8], 8'h00);
        tick(WR_CYC);
    endtask

    initial
    begin
        rst = 1'b1;
        tx_off_pin = 1'b0;
        laser_fault_raw = 1'b0;
        light_present = 1'b0;
        transmit_supply_rail = 8'hA5;
        bad_count = 0;
        num_checks = 0;
        tick(20);
        rst <= 1'b0;
        t_boot();
        t_hw();
        t_light(1'b1, 8'h01);
        t_fault();
        t_soft();
        t_light(1'b0, 8'h03);
        give_verdict();
    end
endmodule
